// ==== dagu_regs.svh ====
`ifndef DAGU_REGS_SVH
`define DAGU_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_PAGE 12'h000
`define OFS_STAT1 12'h004
`define OFS_INDEX 12'h008
`define OFS_POINTER_COMPARE_INSTR 12'h00c
`define OFS_MODE 12'h010
`define OFS_AUX0 12'h020
`define OFS_AUX7 12'h03c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define STAT1_PTR_LSB 0
`define STAT1_SAVE_LSB 3
`define STAT1_TC_BIT 6
`define MODE_COMPAT_BIT 0
`define INSR_MODE_BIT 7
`define INSR_IDX_BIT 6
`define INSR_INC_BIT 5
`define INSR_DEC_BIT 4
`define INSR_RELOAD_BIT 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_COMPAT 1'h0
`define RST_PTR 3'h0

`endif

// ==== dagu_pkg.sv ====
package dagu_pkg;

	typedef enum logic [1:0] {
		CMP_EQ = 2'h0,
		CMP_LT = 2'h1,
		CMP_GT = 2'h2,
		CMP_NE = 2'h3
	} cmp_cond_t;

	typedef enum logic [2:0] {
		STEP_NONE = 3'h0,
		STEP_DN1 = 3'h1,
		STEP_UP1 = 3'h2,
		STEP_RSVD = 3'h3,
		STEP_BR_DN = 3'h4,
		STEP_IDX_DN = 3'h5,
		STEP_IDX_UP = 3'h6,
		STEP_BR_UP = 3'h7
	} step_code_t;

	typedef struct packed {
		logic [8:0] page;
		logic [7:0][15:0] aux;
		logic [2:0] ptr;
		logic [2:0] save;
		logic tc;
		logic [15:0] index;
		logic [15:0] compare;
		logic compat;
		logic [15:0] dir_addr;
		logic dir_v;
		logic [15:0] ind_addr;
		logic ind_v;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} dagu_state_t;

endpackage

// ==== data_address_generation_unit.sv ====
// Overview of operation
// - Direct address is page pointer above offset.
// - Page picks 512 pages, offset 128 words.
// - Reset leaves page pointer untouched.
// - Bit 7 zero marks direct, bits 6..0 offset.
// - Eight 16-bit auxiliary registers cover 64K.
// - Three-bit pointer selects same-numbered register.
// - Operand address is the unmodified register.
// - Pointer arithmetic is unsigned 16-bit.
// - Indirect updates occur at decode time.
// - Bus writes to registers land at execute.
// - Compare writes test flag in status one.
// - Six post-access steps on current register, or none.
// - Step by one adds or subtracts one.
// - Indexed step adds or subtracts index.
// - Bit-reversed step propagates carry backwards.
// - Indirect operation may reload the pointer.
// - Compat clear mirrors register-0 writes, and load writes to any register, to index/compare.
// - Reset clears index compatibility bit.
// - Indirect word: mode, index, inc, dec, reload, value.
// - Step code table incl. reverse-carry combos.
// - Reload saves old pointer into save buffer.
`timescale 1ns/1ns
`include "dagu_regs.svh"

module data_address_generation_unit
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Decode stage
	input wire logic i_dec_valid,
	input wire logic [15:0] i_dec_instr,
	input wire logic i_lar_valid,
	input wire logic [2:0] i_lar_sel,
	input wire logic [15:0] i_lar_data,
	input wire logic i_cmp_valid,
	input wire logic [1:0] i_cmp_cond,
	// Addresses and flags
	output logic [15:0] o_direct_address_bus,
	output logic o_direct_valid,
	output logic [15:0] o_indirect_address,
	output logic o_indirect_valid,
	output logic o_test_control_flag
);

	dagu_pkg::dagu_state_t q_ff;
	dagu_pkg::dagu_state_t nxt_q;
	logic [15:0] cur;
	logic [15:0] step_val;
	logic step_mod;
	logic apb_acc;
	logic apb_wr;
	logic [2:0] aidx;
	logic amap;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] rev16(input logic [15:0] v);
		logic [15:0] r;
		r = '0;
		for (int i = 0; i < 16; i++)
		begin
			r[i] = v[15 - i];
		end
		return r;
	endfunction

	assign cur = q_ff.aux[q_ff.ptr];
	assign apb_acc = i_psel && i_penable && !q_ff.pready;
	assign apb_wr = i_psel && i_penable && q_ff.pready && i_pwrite;
	assign aidx = i_paddr[4:2];
	assign amap = (i_paddr >= `OFS_AUX0) && (i_paddr <= `OFS_AUX7) && (i_paddr[1:0] == 2'h0);

	// ----------------------------------------
	// Auxiliary arithmetic unit
	// ----------------------------------------
	// Reverse carry is obtained by mirroring both operands, so an ordinary
	// adder serves both directions instead of a second carry chain.
	always_comb
	begin
		step_val = cur;
		step_mod = 1'b1;
		unique case (dagu_pkg::step_code_t'(i_dec_instr[6:4]))
			dagu_pkg::STEP_NONE: step_mod = 1'b0;
			dagu_pkg::STEP_RSVD: step_mod = 1'b0;
			dagu_pkg::STEP_DN1: step_val = cur - 16'h0001;
			dagu_pkg::STEP_UP1: step_val = cur + 16'h0001;
			dagu_pkg::STEP_IDX_DN: step_val = cur - q_ff.index;
			dagu_pkg::STEP_IDX_UP: step_val = cur + q_ff.index;
			dagu_pkg::STEP_BR_DN: step_val = rev16(rev16(cur) - rev16(q_ff.index));
			dagu_pkg::STEP_BR_UP: step_val = rev16(rev16(cur) + rev16(q_ff.index));
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		nxt_q = q_ff;
		nxt_q.dir_v = 1'b0;
		nxt_q.ind_v = 1'b0;
		nxt_q.pready = 1'b0;
		nxt_q.pslverr = 1'b0;
		if (i_dec_valid)
		begin
			if (!i_dec_instr[`INSR_MODE_BIT])
			begin
				nxt_q.dir_addr = {q_ff.page, i_dec_instr[6:0]};
				nxt_q.dir_v = 1'b1;
			end
			else
			begin
				nxt_q.ind_addr = cur;
				nxt_q.ind_v = 1'b1;
				nxt_q.aux[q_ff.ptr] = step_val;
				if (step_mod && q_ff.ptr == 3'h0 && !q_ff.compat)
				begin
					nxt_q.index = step_val;
					nxt_q.compare = step_val;
				end
				if (i_dec_instr[`INSR_RELOAD_BIT])
				begin
					nxt_q.save = q_ff.ptr;
					nxt_q.ptr = i_dec_instr[2:0];
				end
			end
		end
		if (i_lar_valid)
		begin
			nxt_q.aux[i_lar_sel] = i_lar_data;
			if (!q_ff.compat)
			begin
				nxt_q.index = i_lar_data;
				nxt_q.compare = i_lar_data;
			end
		end
		if (i_cmp_valid)
		begin
			unique case (dagu_pkg::cmp_cond_t'(i_cmp_cond))
				dagu_pkg::CMP_EQ: nxt_q.tc = (cur == q_ff.compare);
				dagu_pkg::CMP_LT: nxt_q.tc = (cur < q_ff.compare);
				dagu_pkg::CMP_GT: nxt_q.tc = (cur > q_ff.compare);
				dagu_pkg::CMP_NE: nxt_q.tc = (cur != q_ff.compare);
			endcase
		end
		// Bus answer: read data and error are registered in the first access
		// cycle, so every transfer takes exactly one wait state.
		if (apb_acc)
		begin
			nxt_q.pready = 1'b1;
			nxt_q.prdata = 32'h0000_0000;
			if (amap)
			begin
				nxt_q.prdata[15:0] = q_ff.aux[aidx];
			end
			else
			begin
				unique case (i_paddr)
					`OFS_PAGE: nxt_q.prdata[8:0] = q_ff.page;
					`OFS_STAT1: nxt_q.prdata[6:0] = {q_ff.tc, q_ff.save, q_ff.ptr};
					`OFS_INDEX: nxt_q.prdata[15:0] = q_ff.index;
					`OFS_POINTER_COMPARE_INSTR: nxt_q.prdata[15:0] = q_ff.compare;
					`OFS_MODE: nxt_q.prdata[`MODE_COMPAT_BIT] = q_ff.compat;
					default: nxt_q.pslverr = 1'b1;
				endcase
			end
		end
		// Bus writes model the execute-stage path and so override any decode
		// update of the same register in this cycle.
		if (apb_wr && amap)
		begin
			nxt_q.aux[aidx] = i_pwdata[15:0];
			if (aidx == 3'h0 && !q_ff.compat)
			begin
				nxt_q.index = i_pwdata[15:0];
				nxt_q.compare = i_pwdata[15:0];
			end
		end
		else if (apb_wr)
		begin
			unique case (i_paddr)
				`OFS_PAGE: nxt_q.page = i_pwdata[8:0];
				`OFS_STAT1:
				begin
					nxt_q.ptr = i_pwdata[`STAT1_PTR_LSB +: 3];
					nxt_q.save = i_pwdata[`STAT1_SAVE_LSB +: 3];
					nxt_q.tc = i_pwdata[`STAT1_TC_BIT];
				end
				`OFS_INDEX: nxt_q.index = i_pwdata[15:0];
				`OFS_POINTER_COMPARE_INSTR: nxt_q.compare = i_pwdata[15:0];
				`OFS_MODE: nxt_q.compat = i_pwdata[`MODE_COMPAT_BIT];
				default: nxt_q.pslverr = 1'b0;
			endcase
		end
		if (i_rst)
		begin
			// The page pointer keeps its value; software must load it first.
			nxt_q.page = q_ff.page;
			nxt_q.aux = '0;
			nxt_q.ptr = `RST_PTR;
			nxt_q.save = `RST_PTR;
			nxt_q.tc = 1'b0;
			nxt_q.index = 16'h0000;
			nxt_q.compare = 16'h0000;
			nxt_q.compat = `RST_COMPAT;
			nxt_q.dir_addr = 16'h0000;
			nxt_q.dir_v = 1'b0;
			nxt_q.ind_addr = 16'h0000;
			nxt_q.ind_v = 1'b0;
			nxt_q.pready = 1'b0;
			nxt_q.prdata = 32'h0000_0000;
			nxt_q.pslverr = 1'b0;
		end
	end

	always_ff @(posedge i_clk)
	begin
		q_ff <= nxt_q;
	end

	assign o_prdata = q_ff.prdata;
	assign o_pready = q_ff.pready;
	assign o_pslverr = q_ff.pslverr;
	assign o_direct_address_bus = q_ff.dir_addr;
	assign o_direct_valid = q_ff.dir_v;
	assign o_indirect_address = q_ff.ind_addr;
	assign o_indirect_valid = q_ff.ind_v;
	assign o_test_control_flag = q_ff.tc;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	logic quiet;
	assign quiet = !i_lar_valid && !apb_wr;
	logic ind_go;
	assign ind_go = i_dec_valid && i_dec_instr[7] && quiet;

	property p_direct;
		i_dec_valid && !i_dec_instr[7] |=>
			o_direct_valid && o_direct_address_bus == {$past(q_ff.page), $past(i_dec_instr[6:0])};
	endproperty
	a_direct: assert property (p_direct) else $error("direct address wrong");

	property p_ind_old;
		i_dec_valid && i_dec_instr[7] |=> o_indirect_valid && o_indirect_address == $past(cur);
	endproperty
	a_ind_old: assert property (p_ind_old) else $error("indirect address not pre-update");

	property p_up1;
		ind_go && i_dec_instr[6:4] == 3'h2 |=> q_ff.aux[$past(q_ff.ptr)] == $past(cur) + 16'h0001;
	endproperty
	a_up1: assert property (p_up1) else $error("increment by one wrong");

	property p_idx_dn;
		ind_go && i_dec_instr[6:4] == 3'h5 |=>
			q_ff.aux[$past(q_ff.ptr)] == $past(cur) - $past(q_ff.index);
	endproperty
	a_idx_dn: assert property (p_idx_dn) else $error("indexed decrement wrong");

	property p_br_up;
		ind_go && i_dec_instr[6:4] == 3'h7 |=>
			rev16(q_ff.aux[$past(q_ff.ptr)]) == rev16($past(cur)) + rev16($past(q_ff.index));
	endproperty
	a_br_up: assert property (p_br_up) else $error("reverse carry add wrong");

	property p_reload;
		ind_go && i_dec_instr[3] |=>
			q_ff.save == $past(q_ff.ptr) && q_ff.ptr == $past(i_dec_instr[2:0]);
	endproperty
	a_reload: assert property (p_reload) else $error("pointer reload wrong");

	property p_mirror;
		i_lar_valid && !q_ff.compat && !apb_wr |=>
			q_ff.index == $past(i_lar_data) && q_ff.compare == $past(i_lar_data);
	endproperty
	a_mirror: assert property (p_mirror) else $error("compat mirror missing");

	property p_compat_rst;
		disable iff (1'b0) i_rst |=> !q_ff.compat;
	endproperty
	a_compat_rst: assert property (p_compat_rst) else $error("compat not cleared");

	property p_tc;
		i_cmp_valid && i_cmp_cond == 2'h0 && !apb_wr |=>
			o_test_control_flag == ($past(cur) == $past(q_ff.compare));
	endproperty
	a_tc: assert property (p_tc) else $error("compare flag wrong");

	property p_answer;
		i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready;
	endproperty
	a_answer: assert property (p_answer) else $error("bus answer timing wrong");

	c_direct: cover property (i_dec_valid && !i_dec_instr[7]);
	c_br_dn: cover property (ind_go && i_dec_instr[6:4] == 3'h4);
	c_reload: cover property (ind_go && i_dec_instr[3]);
	c_apb_wr: cover property (apb_wr && amap);

endmodule

// ==== testbench.sv ====
`timescale 1ns/1ns
`include "dagu_regs.svh"

`define CHK(a, b) \
	begin \
		comparisons++; \
		if ((a) !== (b)) \
		begin \
			n_mismatch++; \
			$display("unexpected at %0t: got %h expected %h", $time, a, b); \
		end \
	end

module testbench;
	logic i_clk, i_rst, i_psel, i_penable, i_pwrite;
	logic [11:0] i_paddr;
	logic [31:0] i_pwdata, o_prdata, rd;
	logic o_pready, o_pslverr, er;
	logic i_dec_valid, i_lar_valid, i_cmp_valid;
	logic [15:0] i_dec_instr, i_lar_data, o_direct_address_bus, o_indirect_address;
	logic [2:0] i_lar_sel;
	logic [1:0] i_cmp_cond;
	logic o_direct_valid, o_indirect_valid, o_test_control_flag;
	int n_mismatch = 0;
	int comparisons = 0;
	typedef struct {logic [15:0] ins, adr, cur;} row_t;
	// Row 0 leaves register 0 behind and moves the pointer to register 1.
	row_t rows[10] = '{'{16'h0089, 16'h1235, 16'h0100}, '{16'h0080, 16'h0100, 16'h0100},
		'{16'h00a0, 16'h0100, 16'h0101}, '{16'h0090, 16'h0101, 16'h0100},
		'{16'h00b0, 16'h0100, 16'h0100}, '{16'h00e0, 16'h0100, 16'h0108},
		'{16'h00d0, 16'h0108, 16'h0100}, '{16'h00f0, 16'h0100, 16'h0108},
		'{16'h00f0, 16'h0108, 16'h0104}, '{16'h00c0, 16'h0104, 16'h0108}};

	data_address_generation_unit i_dut
	(
		.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
		.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
		.o_pready(o_pready), .o_pslverr(o_pslverr), .i_dec_valid(i_dec_valid),
		.i_dec_instr(i_dec_instr), .i_lar_valid(i_lar_valid), .i_lar_sel(i_lar_sel),
		.i_lar_data(i_lar_data), .i_cmp_valid(i_cmp_valid), .i_cmp_cond(i_cmp_cond),
		.o_direct_address_bus(o_direct_address_bus), .o_direct_valid(o_direct_valid),
		.o_indirect_address(o_indirect_address), .o_indirect_valid(o_indirect_valid),
		.o_test_control_flag(o_test_control_flag)
	);

	initial
	begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	// ----------------------------------------
	// Bus and pipeline drivers
	// ----------------------------------------
	// The answer is sampled at the rising edge, before that edge's own update,
	// so the bench sees exactly what the slave sees when the transfer completes.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		do
		begin
			@(posedge i_clk);
			n++;
		end while (o_pready !== 1'b1 && n < 20);
		if (n >= 20)
			n_mismatch++;
		rd = o_prdata;
		er = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		`CHK(rd, x)
	endtask

	task automatic dec(input logic [15:0] w);
		@(posedge i_clk);
		i_dec_valid <= 1'b1;
		i_dec_instr <= w;
		@(posedge i_clk);
		i_dec_valid <= 1'b0;
		@(negedge i_clk);
	endtask

	task automatic test_done;
		$display("mismatches %0d of %0d comparisons", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		#400000;
		n_mismatch++;
		test_done;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		{i_rst, i_psel, i_penable, i_pwrite, i_dec_valid, i_lar_valid, i_cmp_valid} = 7'h40;
		{i_paddr, i_pwdata, i_dec_instr, i_lar_data, i_lar_sel, i_cmp_cond} = '0;
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		rdc(`OFS_MODE, 32'h0);
		rdc(`OFS_STAT1, 32'h0);
		@(posedge i_clk);
		i_lar_valid <= 1'b1;
		i_lar_data <= 16'h1234;
		@(posedge i_clk);
		i_lar_valid <= 1'b0;
		rdc(`OFS_POINTER_COMPARE_INSTR, 32'h1234);
		dec(16'h00a0);
		`CHK(o_indirect_address, 16'h1234)
		rdc(`OFS_INDEX, 32'h1235);
		apb(1'b1, `OFS_MODE, 32'h1);
		apb(1'b1, `OFS_INDEX, 32'h8);
		apb(1'b1, 12'h024, 32'h100);
		foreach (rows[i])
		begin
			dec(rows[i].ins);
			`CHK(o_indirect_valid, 1'b1)
			`CHK(o_indirect_address, rows[i].adr)
			rdc(12'h024, {16'h0, rows[i].cur});
		end
		rdc(`OFS_STAT1, 32'h1);
		dec(16'h008b);
		rdc(`OFS_STAT1, 32'h0b);
		apb(1'b1, `OFS_POINTER_COMPARE_INSTR, 32'h200);
		for (int c = 0; c < 4; c++)
		begin
			@(posedge i_clk);
			i_cmp_valid <= 1'b1;
			i_cmp_cond <= c[1:0];
			@(posedge i_clk);
			i_cmp_valid <= 1'b0;
			@(negedge i_clk);
			`CHK(o_test_control_flag, 4'b1010 >> c & 1'b1)
		end
		apb(1'b1, 12'h02c, 32'hffff);
		@(posedge i_clk);
		i_dec_valid <= 1'b1;
		i_dec_instr <= 16'h00a0;
		@(negedge i_clk);
		@(negedge i_clk);
		`CHK(o_indirect_address, 16'hffff)
		@(posedge i_clk);
		i_dec_valid <= 1'b0;
		@(negedge i_clk);
		`CHK(o_indirect_address, 16'h0000)
		rdc(12'h02c, 32'h1);
		apb(1'b1, `OFS_PAGE, 32'h1a5);
		dec(16'h3f55);
		`CHK(o_direct_valid, 1'b1)
		`CHK(o_direct_address_bus, 16'hd2d5)
		apb(1'b1, `OFS_PAGE, 32'h1ff);
		dec(16'hff7f);
		`CHK(o_direct_address_bus, 16'hffff)
		rdc(12'h0f0, 32'h0);
		`CHK(er, 1'b1)
		// A second reset in mid-run must keep the page pointer.
		@(posedge i_clk);
		i_rst <= 1'b1;
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		dec(16'h0000);
		`CHK(o_direct_address_bus, 16'hff80)
		rdc(`OFS_MODE, 32'h0);
		rdc(12'h024, 32'h0);
		test_done;
	end
endmodule
